// File: acc_ctrl.sv
// Digital control and output side of a 12-bit pipelined sampling converter.
// Assumes all pins are synchronous to clk_i and software on classic Wishbone.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
module acc_ctrl #(
  parameter int SLEEP_REC_CYC = acc_pkg::SLEEP_REC_CYC,
  parameter int STOP_CYC      = acc_pkg::STOP_CYC
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [acc_pkg::ADR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire logic                              sample_clk_i,
  input  wire logic signed [acc_pkg::RAW_W-1:0]  raw_sample_i,
  input  wire logic [1:0]                        mode_strap_i,
  input  wire logic                              power_down_ctrl_i,
  input  wire logic                              out_drive_n_i,
  input  wire logic                              out_ready_i,
  output logic      [acc_pkg::CODE_W-1:0]        sample_code_o,
  output logic                                   sample_code_oe_o,
  output logic                                   range_flag_o,
  output logic                                   range_flag_oe_o,
  output logic                                   sample_valid_o,
  output logic                                   int_clk_o
);

  localparam int DW    = acc_pkg::CODE_W + 1;
  localparam int CNT_W = $clog2(STOP_CYC + 1);
  localparam int REC_W = $clog2(SLEEP_REC_CYC + acc_pkg::NAP_REC_EDGES + 1);

  generate
    if (SLEEP_REC_CYC < 1 || STOP_CYC <= acc_pkg::MAX_PERIOD_CYC)
    begin : g_bad_param
      $error("acc_ctrl needs SLEEP_REC_CYC >= 1 and STOP_CYC > max period");
    end
  endgenerate

  acc_pkg::acc_pwr_t pwr_reg;
  logic              sclk_prev_reg;
  logic [CNT_W-1:0]  since_reg;
  logic [CNT_W-1:0]  period_reg;
  logic [6:0]        lock_cnt_reg;
  logic [REC_W-1:0]  rec_cnt_reg;
  logic [DW-1:0]     pipe_reg [acc_pkg::PIPE_DEPTH];
  logic [acc_pkg::PIPE_DEPTH-1:0] pv_reg;
  logic              capture_reg;
  logic              overrun_reg;
  logic              rate_fast_reg;
  logic              rate_slow_reg;
  logic [DW-1:0]     last_reg;
  logic              ack_reg;
  logic [31:0]       dat_reg;
  logic              oe_reg;
  logic              int_clk_reg;

  logic              rise;
  logic              stopped;
  logic              dcs_on;
  logic              twos;
  logic              locked;
  logic              powered;
  logic              recovering;
  logic              conv_ok;
  logic [acc_pkg::CODE_W-1:0] fmt_code;
  logic              fmt_over;
  logic              push_valid;
  logic              buf_ready;
  logic [DW-1:0]     buf_data;
  logic              wb_req;
  logic [31:0]       status;

  assign rise    = sample_clk_i & ~sclk_prev_reg;
  assign stopped = since_reg == CNT_W'(STOP_CYC);
  assign dcs_on  = mode_strap_i == acc_pkg::STRAP_THIRD
                 | mode_strap_i == acc_pkg::STRAP_TWO3;
  assign twos    = mode_strap_i == acc_pkg::STRAP_TWO3
                 | mode_strap_i == acc_pkg::STRAP_VDD;
  assign locked  = ~dcs_on
                 | lock_cnt_reg == 7'(acc_pkg::DCS_LOCK_EDGES);
  assign powered = pwr_reg != acc_pkg::ACC_NAP
                 && pwr_reg != acc_pkg::ACC_SLEEP;
  assign recovering = pwr_reg == acc_pkg::ACC_REC_NAP
                   || pwr_reg == acc_pkg::ACC_REC_SLEEP;
  assign conv_ok = pwr_reg == acc_pkg::ACC_RUN && locked;
  assign push_valid = rise & pv_reg[acc_pkg::PIPE_DEPTH-1] & capture_reg;

  acc_fmt u_fmt (
    .raw_i  (raw_sample_i),
    .twos_i (twos),
    .code_o (fmt_code),
    .over_o (fmt_over)
  );

  // Sample clock edge, period measure and stopped detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_prev_reg <= 1'b0;
      since_reg     <= '0;
      period_reg    <= '0;
      rate_fast_reg <= 1'b0;
      rate_slow_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sample_clk_i;
      if (rise)
      begin
        since_reg     <= '0;
        period_reg    <= since_reg + 1'b1;
        rate_fast_reg <= since_reg + 1'b1 < CNT_W'(acc_pkg::MIN_PERIOD_CYC);
        rate_slow_reg <= since_reg + 1'b1 > CNT_W'(acc_pkg::MAX_PERIOD_CYC);
      end
      else if (!stopped)
        since_reg <= since_reg + 1'b1;
      else
        rate_slow_reg <= 1'b1;
    end
  end

  // Internal clock: follows the pin with the stabiliser off; with it on, rises with the pin, falls at half the measured period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_clk_reg <= 1'b0;
    else if (!dcs_on)
      int_clk_reg <= sample_clk_i;
    else if (rise)
      int_clk_reg <= 1'b1;
    else if (since_reg + 1'b1 >= {1'b0, period_reg[CNT_W-1:1]})
      int_clk_reg <= 1'b0;
  end

  // Stabiliser relock after a long stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i || stopped)
      lock_cnt_reg <= '0;
    else if (rise && lock_cnt_reg != 7'(acc_pkg::DCS_LOCK_EDGES))
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
  end

  // Power modes and their recovery
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_reg     <= acc_pkg::ACC_RUN;
      rec_cnt_reg <= '0;
    end
    else if (power_down_ctrl_i)
    begin
      rec_cnt_reg <= '0;
      pwr_reg <= out_drive_n_i ? acc_pkg::ACC_SLEEP
                               : acc_pkg::ACC_NAP;
    end
    else
    begin
      unique case (pwr_reg)
        acc_pkg::ACC_RUN:
          rec_cnt_reg <= '0;
        acc_pkg::ACC_NAP:
          pwr_reg <= acc_pkg::ACC_REC_NAP;
        acc_pkg::ACC_SLEEP:
          pwr_reg <= acc_pkg::ACC_REC_SLEEP;
        acc_pkg::ACC_REC_NAP:
          if (rise)
          begin
            if (rec_cnt_reg == REC_W'(acc_pkg::NAP_REC_EDGES - 1))
              pwr_reg <= acc_pkg::ACC_RUN;
            rec_cnt_reg <= rec_cnt_reg + 1'b1;
          end
        acc_pkg::ACC_REC_SLEEP:
        begin
          if (rec_cnt_reg == REC_W'(SLEEP_REC_CYC - 1))
            pwr_reg <= acc_pkg::ACC_RUN;
          rec_cnt_reg <= rec_cnt_reg + 1'b1;
        end
      endcase
    end
  end

  // Five-stage conversion pipeline, advanced on the rising edge only
  always_ff @(posedge clk_i)
  begin
    if (rise)
    begin
      pipe_reg[0] <= {fmt_over, fmt_code};
      for (int i = 1; i < acc_pkg::PIPE_DEPTH; i++)
        pipe_reg[i] <= pipe_reg[i-1];
    end
    if (rst_i || !powered)
      pv_reg <= '0;
    else if (rise)
      pv_reg <= {pv_reg[acc_pkg::PIPE_DEPTH-2:0], conv_ok};
  end

  acc_buf #(
    .W     (DW),
    .DEPTH (acc_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (buf_ready),
    .in_data_i   (pipe_reg[acc_pkg::PIPE_DEPTH-1]),
    .out_valid_o (sample_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (buf_data)
  );

  assign sample_code_o = buf_data[acc_pkg::CODE_W-1:0];
  assign range_flag_o  = buf_data[acc_pkg::CODE_W];
  assign int_clk_o     = int_clk_reg;

  // Output drivers off under drive control or in sleep and nap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oe_reg <= 1'b0;
    else
      oe_reg <= ~out_drive_n_i & powered;
  end

  assign sample_code_oe_o = oe_reg;
  assign range_flag_oe_o  = oe_reg;

  // Last code pushed to the buffer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      last_reg <= '0;
    else if (push_valid && buf_ready)
      last_reg <= pipe_reg[acc_pkg::PIPE_DEPTH-1];
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb
  begin
    status = '0;
    status[acc_pkg::ST_DCS_ON]    = dcs_on;
    status[acc_pkg::ST_TWOS]      = twos;
    status[acc_pkg::ST_LOCKED]    = locked;
    status[acc_pkg::ST_POWERED]   = powered;
    status[acc_pkg::ST_RECOVER]   = recovering;
    status[acc_pkg::ST_OVERRUN]   = overrun_reg;
    status[acc_pkg::ST_RATE_FAST] = rate_fast_reg;
    status[acc_pkg::ST_RATE_SLOW] = rate_slow_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          acc_pkg::REG_CTRL:   dat_reg <= {31'h0, capture_reg};
          acc_pkg::REG_STATUS: dat_reg <= status;
          acc_pkg::REG_LAST:   dat_reg <= {19'h0, last_reg};
          default:             dat_reg <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_reg <= acc_pkg::CTRL_CAPTURE_RST;
    else if (wb_req && wb_we_i && wb_sel_i[0]
             && wb_adr_i == acc_pkg::REG_CTRL)
      capture_reg <= wb_dat_i[acc_pkg::CTRL_CAPTURE];
  end

  // Overrun sticky; a new overrun wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overrun_reg <= 1'b0;
    else if (push_valid && !buf_ready)
      overrun_reg <= 1'b1;
    else if (wb_req && wb_we_i && wb_sel_i[0]
             && wb_adr_i == acc_pkg::REG_STATUS
             && wb_dat_i[acc_pkg::ST_OVERRUN])
      overrun_reg <= 1'b0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sample_on_rise: assert property (rise |=>
    pipe_reg[0] == $past({fmt_over, fmt_code}))
    else $error("sample not held at rising edge");
  a_relock_wait: assert property (dcs_on && stopped |=> !locked)
    else $error("stabiliser valid right after clock stop");
  a_twos_msb: assert property (!fmt_over && twos |->
    fmt_code == raw_sample_i[acc_pkg::CODE_W-1:0])
    else $error("two's complement code wrong");
  a_clamp_high: assert property (raw_sample_i > acc_pkg::RAW_POS_FS |->
    fmt_over && fmt_code == (twos ? acc_pkg::TWOS_MAX : acc_pkg::OFF_MAX))
    else $error("overrange not clamped");
  a_strap_decode: assert property (
    (mode_strap_i == acc_pkg::STRAP_GND) |-> !dcs_on && !twos)
    else $error("ground strap decoded wrong");
  a_drive_off: assert property (out_drive_n_i |=>
    !sample_code_oe_o && !range_flag_oe_o)
    else $error("outputs driven with drive control high");
  a_sleep_entry: assert property (power_down_ctrl_i && out_drive_n_i
    |=> pwr_reg == acc_pkg::ACC_SLEEP ##1 !sample_code_oe_o)
    else $error("sleep not entered");
  a_nap_recover: assert property (pwr_reg == acc_pkg::ACC_REC_NAP
    && rise && !power_down_ctrl_i
    && rec_cnt_reg == REC_W'(acc_pkg::NAP_REC_EDGES - 1)
    |=> pwr_reg == acc_pkg::ACC_RUN)
    else $error("nap recovery count wrong");
  a_pd_hiz: assert property (!powered |=> !range_flag_oe_o)
    else $error("outputs driven in sleep or nap");
  a_no_push_rec: assert property (recovering |->
    !pv_reg[0])
    else $error("sample taken during recovery");

endmodule : acc_ctrl

// File: acc_pkg.sv
// Shared constants and types of the converter control block.
// Assumes a single 125 MHz system clock and word-aligned Wishbone access.
package acc_pkg;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int CLK_HZ         = 125000000;
  localparam int CODE_W         = 12;
  localparam int RAW_W          = 14;
  localparam int PIPE_DEPTH     = 5;
  localparam int BUF_DEPTH      = 2;

  // Conversion rate limits of the sample clock
  localparam int MAX_RATE_SPS   = 25000000;
  localparam int MIN_RATE_SPS   = 1000000;
  localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_SPS;
  localparam int MAX_PERIOD_CYC = CLK_HZ / MIN_RATE_SPS;

  // Recovery and relock counts, in sample clock edges
  localparam int NAP_REC_EDGES  = 100;
  localparam int DCS_LOCK_EDGES = 100;

  // Sleep recovery time, least time rounded up
  localparam int SLEEP_REC_NS   = 1000000;
  localparam int SLEEP_REC_CYC  =
    (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sample clock idle time that counts as stopped
  localparam int STOP_NS        = 10000;
  localparam int STOP_CYC       = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Format strap levels
  localparam logic [1:0] STRAP_GND   = 2'h0;
  localparam logic [1:0] STRAP_THIRD = 2'h1;
  localparam logic [1:0] STRAP_TWO3  = 2'h2;
  localparam logic [1:0] STRAP_VDD   = 2'h3;

  // Codes
  localparam logic [CODE_W-1:0] CODE_MSB    = 12'h800;
  localparam logic [CODE_W-1:0] OFF_MAX     = 12'hfff;
  localparam logic [CODE_W-1:0] OFF_MIN     = 12'h000;
  localparam logic [CODE_W-1:0] TWOS_MAX    = 12'h7ff;
  localparam logic [CODE_W-1:0] TWOS_MIN    = 12'h800;
  localparam logic signed [RAW_W-1:0] RAW_POS_FS = 14'sh07ff;
  localparam logic signed [RAW_W-1:0] RAW_NEG_FS = -14'sh0800;

  // Register map
  localparam int          ADR_W      = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_LAST   = 8'h08;

  localparam int CTRL_CAPTURE   = 0;
  localparam logic CTRL_CAPTURE_RST = 1'b1;

  localparam int ST_DCS_ON      = 0;
  localparam int ST_TWOS        = 1;
  localparam int ST_LOCKED      = 2;
  localparam int ST_POWERED     = 3;
  localparam int ST_RECOVER     = 4;
  localparam int ST_OVERRUN     = 5;
  localparam int ST_RATE_FAST   = 6;
  localparam int ST_RATE_SLOW   = 7;

  localparam int LAST_RANGE     = 12;

  typedef enum {
    ACC_RUN,
    ACC_NAP,
    ACC_SLEEP,
    ACC_REC_NAP,
    ACC_REC_SLEEP
  } acc_pwr_t;

endpackage : acc_pkg

// File: acc_fmt.sv
// Clamp and output format of one raw sample.
// Assumes the raw value is a signed count of code steps around zero input.
module acc_fmt (
  input  wire logic signed [acc_pkg::RAW_W-1:0]  raw_i,
  input  wire logic                              twos_i,
  output logic             [acc_pkg::CODE_W-1:0] code_o,
  output logic                                   over_o
);

  logic hi;
  logic lo;

  always_comb
  begin
    hi     = raw_i > acc_pkg::RAW_POS_FS;
    lo     = raw_i < acc_pkg::RAW_NEG_FS;
    over_o = hi | lo;
    if (hi)
      code_o = twos_i ? acc_pkg::TWOS_MAX : acc_pkg::OFF_MAX;
    else if (lo)
      code_o = twos_i ? acc_pkg::TWOS_MIN : acc_pkg::OFF_MIN;
    else if (twos_i)
      code_o = raw_i[acc_pkg::CODE_W-1:0];
    else
      code_o = raw_i[acc_pkg::CODE_W-1:0] ^ acc_pkg::CODE_MSB;
  end

endmodule : acc_fmt

// File: acc_buf.sv
// Small shift buffer with valid and ready on both sides.
// Assumes one synchronous active-high reset; head entry is registered.
module acc_buf #(
  parameter int W     = 13,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  generate
    if (DEPTH < 1)
    begin : g_bad_depth
      $error("acc_buf needs DEPTH of at least 1");
    end
  endgenerate

  logic [W-1:0]     mem_reg  [DEPTH];
  logic [W-1:0]     mem_next [DEPTH];
  logic [DEPTH-1:0] v_reg;
  logic [DEPTH-1:0] v_next;
  logic             push;
  logic             pop;
  logic             placed;

  assign pop         = v_reg[0] & out_ready_i;
  assign in_ready_o  = ~v_reg[DEPTH-1] | out_ready_i;
  assign push        = in_valid_i & in_ready_o;
  assign out_valid_o = v_reg[0];
  assign out_data_o  = mem_reg[0];

  always_comb
  begin
    placed   = 1'b0;
    mem_next = mem_reg;
    v_next   = v_reg;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        mem_next[i] = mem_reg[i+1];
        v_next[i]   = v_reg[i+1];
      end
      v_next[DEPTH-1] = 1'b0;
    end
    if (push)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!placed && !v_next[i])
        begin
          mem_next[i] = in_data_i;
          v_next[i]   = 1'b1;
          placed      = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    mem_reg <= mem_next;
    if (rst_i)
      v_reg <= '0;
    else
      v_reg <= v_next;
  end

endmodule : acc_buf

// File: acc_rx.sv
// Receiver model: captures code and flag words off the sample port.
// Assumes outputs registered on clk_i; stall_i holds ready low.
module acc_rx (
  input  wire logic                        clk_i,
  input  wire logic                        valid_i,
  input  wire logic [acc_pkg::CODE_W-1:0]  code_i,
  input  wire logic                        flag_i,
  input  wire logic                        oe_i,
  input  wire logic                        stall_i,
  output logic                             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] got[$];
  logic        rdy_reg = 1'b0;
  assign ready_o = rdy_reg;
  // Hi-Z lines carry nothing, so only driven words count
  always @(posedge clk_i)
  begin
    rdy_reg <= !stall_i;
    if (valid_i && ready_o && oe_i)
      got.push_back({flag_i, code_i});
  end
endmodule : acc_rx

// File: tb.sv
// Testbench of the converter control block with a receiver model.
// Assumes 125 MHz clk_i and a sample clock of six system cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd_q;
  logic ack, sclk = 1'b0, pwr = 1'b0, drv_n = 1'b0, stall = 1'b0, rdy;
  logic signed [13:0] raw = 14'sh0000;
  logic [1:0]  strap = acc_pkg::STRAP_GND;
  logic [11:0] code;
  logic code_oe, flag, flag_oe, valid, iclk;
  logic [12:0] expq[$], lastv;
  bit twos = 1'b0;
  int n_errors = 0, checked = 0;
  int vals[14] = '{0, 1, -1, 2047, 2048, -2048, -2049, 8191, -8192,
                   0, 0, 0, 0, 0};

  always #4 clk_i = ~clk_i;

  acc_ctrl #(.SLEEP_REC_CYC(20), .STOP_CYC(200)) i_acc_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sample_clk_i(sclk),
    .raw_sample_i(raw), .mode_strap_i(strap), .power_down_ctrl_i(pwr),
    .out_drive_n_i(drv_n), .out_ready_i(rdy), .sample_code_o(code),
    .sample_code_oe_o(code_oe), .range_flag_o(flag),
    .range_flag_oe_o(flag_oe), .sample_valid_o(valid), .int_clk_o(iclk));

  acc_rx i_acc_rx (
    .clk_i(clk_i), .valid_i(valid), .code_i(code), .flag_i(flag),
    .oe_i(code_oe), .stall_i(stall), .ready_o(rdy));

  task print_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd_q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask : rdc

  function automatic logic [12:0] expv(int r);
    logic [12:0] v;
    v = r > 2047 ? 13'h1fff : r < -2048 ? 13'h1000 : {1'b0, 12'(r + 2048)};
    if (twos)
      v[11] = ~v[11];
    return v;
  endfunction : expv

  task send(input int r, input bit rec);
    raw <= r[13:0];
    repeat (3) @(posedge clk_i);
    sclk <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(iclk, 1'b1);
    sclk <= 1'b0;
    if (rec)
      expq.push_back(expv(r));
  endtask : send

  // Five samples stay inside the pipeline
  task cmp_stream;
    repeat (6) @(posedge clk_i);
    chk(i_acc_rx.got.size(), expq.size() - 5);
    while (i_acc_rx.got.size() > 0)
    begin
      lastv = expq.pop_front();
      chk(i_acc_rx.got.pop_front(), lastv);
    end
  endtask : cmp_stream

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({code_oe, flag_oe}, 2'h3);
    rdc(acc_pkg::REG_CTRL, 32'h1, 32'h1);
    rdc(acc_pkg::REG_STATUS, 32'hc, 32'hc);
    wb(1'b1, 8'h10, 32'hffff_ffff);
    rdc(8'h10, 32'hffff_ffff, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      strap <= 2'(s);
      repeat (2) @(posedge clk_i);
      rdc(acc_pkg::REG_STATUS, 32'h3, 32'({s[1], s[1] ^ s[0]}));
    end
    strap <= acc_pkg::STRAP_GND;
    drv_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({code_oe, flag_oe}, 2'h0);
    drv_n <= 1'b0;
    foreach (vals[i]) send(vals[i], 1'b1);
    cmp_stream();
    rdc(acc_pkg::REG_LAST, 32'h1fff, 32'(lastv));
    stall <= 1'b1;
    repeat (8) send(0, 1'b1);
    rdc(acc_pkg::REG_STATUS, 32'h20, 32'h20);
    wb(1'b1, acc_pkg::REG_STATUS, 32'h20);
    rdc(acc_pkg::REG_STATUS, 32'h20, 32'h0);
    stall <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(i_acc_rx.got.size(), 2);
    chk(i_acc_rx.got[1], expv(0));
    strap <= acc_pkg::STRAP_THIRD;
    repeat (210) @(posedge clk_i);
    rdc(acc_pkg::REG_STATUS, 32'h4, 32'h0);
    repeat (110) send(0, 1'b0);
    rdc(acc_pkg::REG_STATUS, 32'h5, 32'h5);
    pwr <= 1'b1;
    repeat (130) @(posedge clk_i);
    chk({code_oe, flag_oe}, 2'h0);
    pwr <= 1'b0;
    i_acc_rx.got.delete();
    repeat (94) send(0, 1'b0);
    chk(i_acc_rx.got.size(), 0);
    repeat (20) send(0, 1'b0);
    chk(i_acc_rx.got.size(), 9);
    drv_n <= 1'b1;
    pwr <= 1'b1;
    strap <= acc_pkg::STRAP_VDD;
    twos = 1'b1;
    repeat (3) @(posedge clk_i);
    chk({code_oe, flag_oe}, 2'h0);
    pwr <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdc(acc_pkg::REG_STATUS, 32'h10, 32'h10);
    repeat (30) @(posedge clk_i);
    drv_n <= 1'b0;
    rdc(acc_pkg::REG_STATUS, 32'h1b, 32'h0a);
    i_acc_rx.got.delete();
    expq.delete();
    foreach (vals[i]) send(vals[i], 1'b1);
    cmp_stream();
    print_verdict();
  end
endmodule : tb
